// ==== rtl/timer_pkg.sv ====
package timer_pkg;

    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int MAX_TIMERS = 3;

    // per-timer window: index in addr[3:2], register in addr[1:0]
    localparam logic [1:0] REG_COUNT = 2'h0;
    localparam logic [1:0] REG_PERIOD = 2'h1;
    localparam logic [1:0] REG_CONTROL = 2'h2;
    localparam logic [3:0] ADDR_FLAGS = 4'hC;
    localparam logic [3:0] ADDR_ENABLES = 4'hD;

    // timer_control fields
    localparam int CTRL_PRE_LSB = 0;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_POST_LSB = 3;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;

    // reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // prescale_select codes and terminal counts
    localparam logic [1:0] PRE_SEL_1 = 2'h0;
    localparam logic [1:0] PRE_SEL_4 = 2'h1;
    localparam logic [1:0] PRE_SEL_16 = 2'h2;
    localparam logic [5:0] PRE_LAST_1 = 6'h00;
    localparam logic [5:0] PRE_LAST_4 = 6'h03;
    localparam logic [5:0] PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_64 = 6'h3F;

    // last oscillator phase of the four per instruction cycle
    localparam logic [1:0] INST_PHASE_LAST = 2'h3;

endpackage

// ==== rtl/timer_channel.sv ====
`timescale 1ns/1ps

module timer_channel (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // timing
    input wire logic inst_tick,
    input wire logic sleep_mode,
    // register writes
    input wire logic count_wr,
    input wire logic period_wr,
    input wire logic control_wr,
    input wire logic [7:0] wdata,
    // state
    output logic [7:0] timer_count,
    output logic [7:0] period_value,
    output logic [7:0] timer_control,
    output logic match_pulse,
    output logic post_event
);

    logic [5:0] pre_count;
    logic [3:0] post_count;
    logic [5:0] pre_last;
    logic [1:0] pre_sel;
    logic [3:0] post_sel;
    logic scaler_clear;
    logic running;
    logic pre_done;
    logic count_step;
    logic at_match;
    logic post_done;

    assign pre_sel = timer_control[timer_pkg::CTRL_PRE_LSB +: 2];
    assign post_sel = timer_control[timer_pkg::CTRL_POST_LSB +: 4];
    assign pre_last = (pre_sel == timer_pkg::PRE_SEL_1) ? timer_pkg::PRE_LAST_1 :
                      (pre_sel == timer_pkg::PRE_SEL_4) ? timer_pkg::PRE_LAST_4 :
                      (pre_sel == timer_pkg::PRE_SEL_16) ? timer_pkg::PRE_LAST_16 :
                      timer_pkg::PRE_LAST_64;
    assign scaler_clear = count_wr | control_wr;
    assign running = timer_control[timer_pkg::CTRL_RUN_BIT] & ~sleep_mode;
    assign pre_done = (pre_count == pre_last);
    assign count_step = running & inst_tick & pre_done;
    assign at_match = (timer_count == period_value);
    assign post_done = (post_count == post_sel);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_count <= 6'h00;
            post_count <= 4'h0;
            timer_count <= timer_pkg::COUNT_RESET;
            period_value <= timer_pkg::PERIOD_RESET;
            timer_control <= timer_pkg::CONTROL_RESET;
            match_pulse <= 1'b0;
            post_event <= 1'b0;
        end else begin
            match_pulse <= count_step & at_match & ~count_wr;
            post_event <= count_step & at_match & ~count_wr & post_done & ~control_wr;
            if (period_wr) begin
                period_value <= wdata;
            end
            if (control_wr) begin
                timer_control <= wdata & timer_pkg::CTRL_WRITE_MASK;
            end
            if (scaler_clear) begin
                pre_count <= 6'h00;
            end else if (running && inst_tick) begin
                pre_count <= pre_done ? 6'h00 : pre_count + 6'h01;
            end
            // software write wins over a same-cycle step
            if (count_wr) begin
                timer_count <= wdata;
            end else if (count_step) begin
                timer_count <= at_match ? 8'h00 : timer_count + 8'h01;
            end
            if (scaler_clear) begin
                post_count <= 4'h0;
            end else if (count_step && at_match) begin
                post_count <= post_done ? 4'h0 : post_count + 4'h1;
            end
        end
    end

endmodule

// ==== rtl/period_match_timer.sv ====
`timescale 1ns/1ps

module period_match_timer #(
    parameter int NUM_TIMERS = timer_pkg::MAX_TIMERS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register port
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::DATA_W-1:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [timer_pkg::DATA_W-1:0] rdata,
    // power state
    input wire logic sleep_mode,
    // to capture/compare/PWM units
    output logic [NUM_TIMERS-1:0] match_pulse,
    // to sync serial units
    output logic spi_shift_clk,
    // interrupt requests
    output logic [NUM_TIMERS-1:0] irq_request
);

    logic [1:0] inst_phase;
    logic inst_tick;
    logic [NUM_TIMERS-1:0] match_w;
    logic [NUM_TIMERS-1:0] post_w;
    logic [NUM_TIMERS-1:0] match_flag;
    logic [NUM_TIMERS-1:0] match_irq_enable;
    logic [NUM_TIMERS-1:0] next_match_flag;
    logic [NUM_TIMERS-1:0] count_wr_w;
    logic [7:0] count_w [NUM_TIMERS];
    logic [7:0] period_w [NUM_TIMERS];
    logic [7:0] control_w [NUM_TIMERS];
    logic [7:0] rd_part [NUM_TIMERS];
    logic flags_sel;
    logic enables_sel;
    logic [7:0] timers_rd;
    logic [7:0] status_rd;
    logic [7:0] next_rdata;
    logic any_wr;

    // instruction clock: one tick per four oscillator cycles
    assign inst_tick = (inst_phase == timer_pkg::INST_PHASE_LAST);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inst_phase <= 2'h0;
        end else begin
            inst_phase <= inst_phase + 2'h1;
        end
    end

    assign flags_sel = (addr == timer_pkg::ADDR_FLAGS);
    assign enables_sel = (addr == timer_pkg::ADDR_ENABLES);
    assign any_wr = wr_strobe;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
            logic win_sel;
            logic period_wr;
            logic control_wr;

            assign win_sel = (addr[3:2] == 2'(gi));
            assign count_wr_w[gi] = wr_strobe & win_sel & (addr[1:0] == timer_pkg::REG_COUNT);
            assign period_wr = wr_strobe & win_sel & (addr[1:0] == timer_pkg::REG_PERIOD);
            assign control_wr = wr_strobe & win_sel & (addr[1:0] == timer_pkg::REG_CONTROL);

            assign rd_part[gi] = !win_sel ? 8'h00 :
                                 (addr[1:0] == timer_pkg::REG_COUNT) ? count_w[gi] :
                                 (addr[1:0] == timer_pkg::REG_PERIOD) ? period_w[gi] :
                                 (addr[1:0] == timer_pkg::REG_CONTROL) ? control_w[gi] :
                                 8'h00;

            timer_channel u_channel (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .inst_tick(inst_tick),
                .sleep_mode(sleep_mode),
                .count_wr(count_wr_w[gi]),
                .period_wr(period_wr),
                .control_wr(control_wr),
                .wdata(wdata),
                .timer_count(count_w[gi]),
                .period_value(period_w[gi]),
                .timer_control(control_w[gi]),
                .match_pulse(match_w[gi]),
                .post_event(post_w[gi])
            );
        end
    endgenerate

    // windows never overlap, so an OR merges them
    always_comb begin
        timers_rd = 8'h00;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            timers_rd = timers_rd | rd_part[i];
        end
    end

    assign status_rd = flags_sel ? 8'(match_flag) :
                       enables_sel ? 8'(match_irq_enable) : 8'h00;
    assign next_rdata = rd_strobe ? (timers_rd | status_rd) : 8'h00;

    // hardware set beats a same-cycle software clear
    assign next_match_flag = ((wr_strobe && flags_sel) ? wdata[NUM_TIMERS-1:0] : match_flag)
                             | post_w;

    assign match_pulse = match_w;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
            match_flag <= '0;
            match_irq_enable <= '0;
            irq_request <= '0;
            spi_shift_clk <= 1'b0;
        end else begin
            rdata <= next_rdata;
            match_flag <= next_match_flag;
            if (wr_strobe && enables_sel) begin
                match_irq_enable <= wdata[NUM_TIMERS-1:0];
            end
            irq_request <= match_flag & match_irq_enable;
            // half rate of timer 0 matches gives a square shift clock
            spi_shift_clk <= spi_shift_clk ^ match_w[0];
        end
    end

    // assertions on timer 0 and the shared status logic
    a_inst_tick_rate: assert property (@(posedge core_clk) disable iff (!reset_n)
        inst_tick |=> !inst_tick [*3] ##1 inst_tick)
        else $error("instruction tick not every fourth cycle");

    a_match_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
        match_w[0] |-> $past(count_w[0]) == $past(period_w[0]))
        else $error("match without equal count and period");

    a_match_zero_count: assert property (@(posedge core_clk) disable iff (!reset_n)
        match_w[0] |-> count_w[0] == 8'h00)
        else $error("count not zero after match");

    a_step_by_one: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($past(inst_tick) && $past(control_w[0][2:0]) == 3'h4 && !$past(sleep_mode)
         && !$past(any_wr) && $past(count_w[0]) != $past(period_w[0]))
        |-> count_w[0] == $past(count_w[0]) + 8'h01)
        else $error("count did not step at 1:1 prescale");

    // at 1:4 a step is sixteen cycles from the next, so eight cycles later nothing moves
    a_prescale_four: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($changed(count_w[0]) && !$past(any_wr) && !any_wr && control_w[0][2:0] == 3'h5)
        ##1 (!any_wr [*8]) |-> $stable(count_w[0]))
        else $error("count stepped early at 1:4 prescale");

    a_sleep_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($past(sleep_mode) && !$past(any_wr)) |-> $stable(count_w[0]) && $stable(period_w[0]))
        else $error("timer moved during sleep");

    a_run_halts: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!$past(control_w[0][2]) && !$past(any_wr)) |-> $stable(count_w[0]) && !match_w[0])
        else $error("halted timer advanced");

    a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(post_w[0]) |-> match_flag[0])
        else $error("postscaler event lost");

    a_irq_gating: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq_request[0] |-> $past(match_flag[0]) && $past(match_irq_enable[0]))
        else $error("interrupt without flag and enable");

    a_read_count: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rd_strobe && addr == 4'h0) |=> rdata == $past(count_w[0]))
        else $error("count read data wrong");

    a_post_only_match: assert property (@(posedge core_clk) disable iff (!reset_n)
        post_w[0] |-> match_w[0])
        else $error("postscaler event without match");

    a_write_clears_post: assert property (@(posedge core_clk) disable iff (!reset_n)
        count_wr_w[0] |=> !post_w[0])
        else $error("postscaler event right after count write");

    c_match: cover property (@(posedge core_clk) disable iff (!reset_n) match_w[0]);
    c_flag: cover property (@(posedge core_clk) disable iff (!reset_n) post_w[0]);
    c_irq: cover property (@(posedge core_clk) disable iff (!reset_n) irq_request[0]);
    c_set_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
        post_w[0] && wr_strobe && flags_sel && !wdata[0]);

endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic sleep_mode = 1'b0;
    logic [7:0] rdata;
    logic [2:0] match_pulse;
    logic spi_shift_clk;
    logic [2:0] irq_request;
    int num_errors = 0;
    int comparisons = 0;
    int cyc;
    int hits;
    logic spi_before;
    logic [7:0] seen_a;
    logic [7:0] seen_b;

    period_match_timer #(.NUM_TIMERS(3)) dut_u (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .addr(addr),
        .wdata(wdata),
        .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe),
        .rdata(rdata),
        .sleep_mode(sleep_mode),
        .match_pulse(match_pulse),
        .spi_shift_clk(spi_shift_clk),
        .irq_request(irq_request)
    );

    always #20 core_clk = ~core_clk;

    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask

    function automatic logic [3:0] ra(input int t, input int r);
        return 4'(4 * t + r);
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge core_clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_check(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask

    // edges up to and including the next match of timer t
    task automatic next_match(input int t, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 2000) begin
                check("match wait", 1, 0);
                complete_run();
            end
        end while (match_pulse[t] !== 1'b1);
    endtask

    // matches seen until the interrupt request of timer t rises
    task automatic count_to_irq(input int t, output int m);
        int n;
        m = 0;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            if (match_pulse[t] === 1'b1) m++;
            if (n > 9000) begin
                check("irq wait", 1, 0);
                complete_run();
            end
        end while (irq_request[t] !== 1'b1);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int t = 0; t < 3; t++) begin
            rd_check("count reset", ra(t, 0), 8'h00);
            rd_check("period reset", ra(t, 1), 8'hFF);
            rd_check("control reset", ra(t, 2), 8'h00);
            rd_check("unmapped", ra(t, 3), 8'h00);
            wr(ra(t, 1), 8'h5A ^ 8'(t));
            rd_check("period rw", ra(t, 1), 8'h5A ^ 8'(t));
            wr(ra(t, 0), 8'hA5);
            rd_check("count rw", ra(t, 0), 8'hA5);
            wr(ra(t, 2), 8'hFF);
            rd_check("control rw", ra(t, 2), 8'h7F);
            wr(ra(t, 2), 8'h00);
        end
        rd_check("flags reset", 4'hC, 8'h00);
        rd_check("unmapped", 4'hE, 8'h00);
        repeat (100) @(posedge core_clk);
        rd_check("halted count", ra(0, 0), 8'hA5);
        // every prescale code, spread over the instances
        for (int c = 0; c < 4; c++) begin
            int t;
            t = (c + 2) % 3;
            wr(ra(t, 1), 8'h02);
            wr(ra(t, 0), 8'h00);
            wr(ra(t, 2), 8'h04 | 8'(c));
            next_match(t, cyc);
            spi_before = spi_shift_clk;
            next_match(t, cyc);
            check("match interval", cyc, 12 << (2 * c));
            if (t == 0) check("spi clock", spi_shift_clk, !spi_before);
            wr(ra(t, 2), 8'h00);
        end
        // postscale ratios and flag recurrence on timer 0
        wr(4'hD, 8'h01);
        for (int k = 0; k < 3; k++) begin
            int code;
            code = (k == 0) ? 0 : ((k == 1) ? 2 : 15);
            wr(ra(0, 1), 8'h07);
            wr(ra(0, 0), 8'h00);
            wr(4'hC, 8'h00);
            wr(ra(0, 2), 8'h04 | 8'(code << 3));
            count_to_irq(0, hits);
            check("matches per flag", hits, code + 1);
            rd_check("flag latched", 4'hC, 8'h01);
            wr(4'hC, 8'h00);
            count_to_irq(0, hits);
            check("matches after restart", hits, code + 1);
            wr(ra(0, 2), 8'h00);
        end
        wr(4'hD, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        check("masked irq", irq_request[0], 1'b0);
        rd_check("flag kept", 4'hC, 8'h01);
        // count write restarts the prescaler
        wr(ra(1, 1), 8'h10);
        wr(ra(1, 2), 8'h06);
        repeat (37) @(posedge core_clk);
        wr(ra(1, 0), 8'h10);
        next_match(1, cyc);
        check("first step delay", cyc >= 57 && cyc <= 64, 1);
        // sleep freezes the counter
        wr(ra(1, 1), 8'hFF);
        wr(ra(1, 2), 8'h04);
        @(posedge core_clk);
        sleep_mode <= 1'b1;
        rd(ra(1, 0), seen_a);
        repeat (60) @(posedge core_clk);
        rd_check("count in sleep", ra(1, 0), seen_a);
        rd_check("period in sleep", ra(1, 1), 8'hFF);
        @(posedge core_clk);
        sleep_mode <= 1'b0;
        repeat (20) @(posedge core_clk);
        rd(ra(1, 0), seen_b);
        check("count after sleep", seen_b !== seen_a, 1);
        complete_run();
    end
endmodule
